// >>> bbs_sram_port.sv
// Device side of a burst-of-two SRAM port with per-lane write selects.
// Assumes the controller runs on clk_i; even edges are K rises, odd K-bar.
`timescale 1ns/1ps
module bbs_sram_port (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            load_strobe_n_i,
  input  wire logic                            rd_not_wr_i,
  input  wire logic [bbs_pkg::ADDR_W-1:0]      addr_i,
  input  wire logic [bbs_pkg::DATA_W-1:0]      wdata_i,
  input  wire logic [bbs_pkg::LANES-1:0]       lane_write_sel_n_i,
  input  wire logic                            strap_out_clk_high_i,
  output logic [bbs_pkg::DATA_W-1:0]           rdata_o,
  output logic                                 rdata_oe_o,
  output logic                                 single_clk_mode_o,
  output logic                                 wbuf_ready_o
);
  localparam int PL = bbs_pkg::PIPE_LEN;
  localparam int AW = bbs_pkg::ADDR_W;
  localparam int DW = bbs_pkg::DATA_W;
  localparam int FD = bbs_pkg::FIFO_DEPTH;

  // Second beat address: lowest bit inverted
  function automatic logic [AW-1:0] burst_next(input logic [AW-1:0] a);
    burst_next = {a[AW-1:1], ~a[0]};
  endfunction

  // Replace the selected lanes of base when the beat hits addr
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] base,
                                               input bbs_pkg::bbs_beat_t b,
                                               input logic [AW-1:0] a);
    lane_merge = base;
    for (int l = 0; l < bbs_pkg::LANES; l++) begin
      if (b.addr == a && !b.sel_n[l]) begin
        lane_merge[l*bbs_pkg::LANE_W +: bbs_pkg::LANE_W] =
          b.data[l*bbs_pkg::LANE_W +: bbs_pkg::LANE_W];
      end
    end
  endfunction

  logic [DW-1:0]           array_r [2**AW];
  logic                    ph_r;
  logic [PL-1:0]           wr_sr_r;
  logic [PL-1:0]           rd_sr_r;
  logic [AW-1:0]           addr_sr_r [PL];
  bbs_pkg::bbs_beat_t      post_r [2];
  logic [1:0]              post_vld_r;
  logic [DW-1:0]           rdata_r;
  logic                    rdata_oe_r;
  logic [1:0]              strap_sync_r;
  logic [2:0]              strap_wait_r;
  logic                    single_clk_r;
  logic                    wbuf_ready_r;

  // Command decode on K rises only; a high strobe is a no-operation
  wire k_edge  = ~ph_r;
  wire new_wr  = k_edge & ~load_strobe_n_i & ~rd_not_wr_i;
  wire new_rd  = k_edge & ~load_strobe_n_i & rd_not_wr_i;

  // Beat timing within the burst
  wire wb0     = wr_sr_r[bbs_pkg::WB0_STAGE];
  wire wb1     = wr_sr_r[bbs_pkg::WB1_STAGE];
  wire rb0     = rd_sr_r[bbs_pkg::RB0_STAGE];
  wire rb1     = rd_sr_r[bbs_pkg::RB1_STAGE];
  wire rd_act  = rb0 | rb1;

  // Incoming beat with the selects that came with it
  wire [AW-1:0] wb_addr = wb0 ? addr_sr_r[bbs_pkg::WB0_STAGE]
                              : burst_next(addr_sr_r[bbs_pkg::WB1_STAGE]);
  wire [AW-1:0] rd_addr = rb0 ? addr_sr_r[bbs_pkg::RB0_STAGE]
                              : burst_next(addr_sr_r[bbs_pkg::RB1_STAGE]);
  bbs_pkg::bbs_beat_t cur_beat;
  assign cur_beat = '{addr: wb_addr, data: wdata_i, sel_n: lane_write_sel_n_i};

  // Held beat with any lane selected leaves for the array when the next write overwrites its slot
  wire slot1         = wb1;
  wire wb_any        = wb0 | wb1;
  bbs_pkg::bbs_beat_t old_beat;
  assign old_beat    = slot1 ? post_r[1] : post_r[0];
  wire old_vld       = slot1 ? post_vld_r[1] : post_vld_r[0];
  wire push_valid    = wb_any & old_vld & ~(&old_beat.sel_n);
  wire fifo_in_ready;

  bbs_pkg::bbs_beat_t              drain_beat;
  logic                            drain_valid;
  logic [FD-1:0][bbs_pkg::BEAT_W-1:0] fifo_entries;
  logic [FD-1:0]                   fifo_live;

  // Drain waits while a read owns the single array port
  wire drain_go = drain_valid & ~rd_act;

  bbs_fifo #(
    .WIDTH (bbs_pkg::BEAT_W),
    .DEPTH (FD)
  ) u_wbuf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (old_beat),
    .out_valid_o (drain_valid),
    .out_ready_i (~rd_act),
    .out_data_o  (drain_beat),
    .entries_o   (fifo_entries),
    .live_o      (fifo_live)
  );

  // Read word: array, then queued beats oldest first, then held beats
  logic [DW-1:0] rd_word;
  always_comb begin
    rd_word = array_r[rd_addr];
    for (int i = 0; i < FD; i++) begin
      if (fifo_live[i]) begin
        rd_word = lane_merge(rd_word, bbs_pkg::bbs_beat_t'(fifo_entries[i]), rd_addr);
      end
    end
    for (int s = 0; s < 2; s++) begin
      if (post_vld_r[s]) begin
        rd_word = lane_merge(rd_word, post_r[s], rd_addr);
      end
    end
  end

  // Phase and command pipelines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_r    <= 1'b0;
      wr_sr_r <= '0;
      rd_sr_r <= '0;
      for (int i = 0; i < PL; i++) begin
        addr_sr_r[i] <= '0;
      end
    end else begin
      ph_r         <= ~ph_r;
      wr_sr_r      <= {wr_sr_r[PL-2:0], new_wr};
      rd_sr_r      <= {rd_sr_r[PL-2:0], new_rd};
      addr_sr_r[0] <= addr_i;
      for (int i = 1; i < PL; i++) begin
        addr_sr_r[i] <= addr_sr_r[i-1];
      end
    end
  end

  // Posted write registers, one per beat slot
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      post_r[0]  <= '0;
      post_r[1]  <= '0;
      post_vld_r <= '0;
    end else if (wb_any) begin
      post_r[slot1]     <= cur_beat;
      post_vld_r[slot1] <= 1'b1;
    end
  end

  // Array commit lane by lane; unselected lanes keep their contents
  always_ff @(posedge clk_i) begin
    if (drain_go) begin
      for (int l = 0; l < bbs_pkg::LANES; l++) begin
        if (!drain_beat.sel_n[l]) begin
          array_r[drain_beat.addr][l*bbs_pkg::LANE_W +: bbs_pkg::LANE_W] <=
            drain_beat.data[l*bbs_pkg::LANE_W +: bbs_pkg::LANE_W];
        end
      end
    end
  end

  // Output registers; they simply hold if the clock stops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r    <= bbs_pkg::RDATA_RST;
      rdata_oe_r <= 1'b0;
    end else begin
      rdata_r    <= rd_act ? rd_word : rdata_r;
      rdata_oe_r <= rd_act;
    end
  end

  // Strap taken on the edge at which the second stage first holds the pin;
  // an earlier capture would freeze the synchroniser's reset value instead
  wire strap_load = strap_wait_r[1] & ~strap_wait_r[2];

  // Strap caught once after reset release, then frozen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_sync_r  <= 2'h0;
      strap_wait_r  <= 3'h0;
      single_clk_r  <= 1'b0;
      wbuf_ready_r  <= 1'b0;
    end else begin
      strap_sync_r  <= {strap_sync_r[0], strap_out_clk_high_i};
      strap_wait_r  <= {strap_wait_r[1:0], 1'b1};
      single_clk_r  <= strap_load ? strap_sync_r[1] : single_clk_r;
      wbuf_ready_r  <= fifo_in_ready;
    end
  end

  assign rdata_o           = rdata_r;
  assign rdata_oe_o        = rdata_oe_r;
  assign single_clk_mode_o = single_clk_r;
  assign wbuf_ready_o      = wbuf_ready_r;
endmodule

// >>> bbs_pkg.sv
// Shared constants and beat carrier for the burst-of-two SRAM port.
// Assumes one 250 MHz clock whose edges alternate as K and K-bar rises.
package bbs_pkg;
  localparam int ADDR_W     = 20;
  localparam int LANE_W     = 9;
  localparam int LANES      = 2;                 // 4 for the 36-bit variant
  localparam int DATA_W     = LANES * LANE_W;
  localparam int FIFO_DEPTH = 16;
  // Half-cycle stages after the command edge
  localparam int PIPE_LEN   = 4;
  localparam int WB0_STAGE  = 1;
  localparam int WB1_STAGE  = 2;
  localparam int RB0_STAGE  = 2;
  localparam int RB1_STAGE  = 3;
  localparam logic [DATA_W-1:0] RDATA_RST = '0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  sel_n;
  } bbs_beat_t;

  localparam int BEAT_W = $bits(bbs_beat_t);
endpackage

// >>> bbs_fifo.sv
// Write-beat FIFO between the posted-write registers and the array.
// Assumes the drain side may stall; all entries are visible for bypass.
`timescale 1ns/1ps
module bbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         in_valid_i,
  output logic                              in_ready_o,
  input  wire logic [WIDTH-1:0]             in_data_i,
  output logic                              out_valid_o,
  input  wire logic                         out_ready_i,
  output logic [WIDTH-1:0]                  out_data_o,
  output logic [DEPTH-1:0][WIDTH-1:0]       entries_o,
  output logic [DEPTH-1:0]                  live_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Entries oldest first, so a later match overrides an earlier one
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      entries_o[i] = mem_r[AW'(rd_ptr_r + AW'(i))];
      live_o[i]    = ((AW+1)'(i) < count_r);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_r  <= (AW+1)'(count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

  // Storage needs no reset; only counted entries are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
endmodule

// >>> bbs_port_sva.sv
// Port checker for the burst-of-two SRAM port.
// Assumes the first edge after reset is a K rise, as in the design.
`timescale 1ns/1ps
module bbs_port_sva (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       load_strobe_n_i,
  input wire logic                       rd_not_wr_i,
  input wire logic [bbs_pkg::DATA_W-1:0] rdata_o,
  input wire logic                       rdata_oe_o,
  input wire logic                       strap_out_clk_high_i,
  input wire logic                       single_clk_mode_o,
  input wire logic                       wbuf_ready_o
);
  logic kph_r;
  logic kcmd_rd;
  // Phase tracker, low before a K rise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) kph_r <= 1'b0;
    else kph_r <= ~kph_r;
  end
  assign kcmd_rd = !kph_r && !load_strobe_n_i && rd_not_wr_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rd_oe_beats: assert property (kcmd_rd |-> ##4 rdata_oe_o [*2])
    else $error("read beats not driven");
  a_oe_release: assert property (kcmd_rd ##2 !kcmd_rd |-> ##4 !rdata_oe_o)
    else $error("bus not released after read");
  a_oe_cause: assert property (rdata_oe_o |-> $past(kcmd_rd, 4) || $past(kcmd_rd, 5))
    else $error("bus driven without a read");
  a_rdata_holds: assert property (!rdata_oe_o && !$past(rdata_oe_o) |-> $stable(rdata_o))
    else $error("idle read data moved");
  a_idle_after_rst: assert property ($fell(rst_i) |-> !rdata_oe_o [*4])
    else $error("bus driven after reset");
  a_ready_after_rst: assert property ($fell(rst_i) |=> wbuf_ready_o)
    else $error("write buffer not ready");
  a_strap_on: assert property (strap_out_clk_high_i [*4] |=> single_clk_mode_o)
    else $error("strap not reported");
  a_oe_phase: assert property ($rose(rdata_oe_o) |-> !kph_r)
    else $error("read beat on wrong edge");
  cover property (kcmd_rd);
  cover property (!kph_r && !load_strobe_n_i && !rd_not_wr_i);
  cover property (!kph_r && load_strobe_n_i && rd_not_wr_i);
endmodule
bind bbs_sram_port bbs_port_sva u_bbs_port_sva (
  .clk_i(clk_i), .rst_i(rst_i), .load_strobe_n_i(load_strobe_n_i),
  .rd_not_wr_i(rd_not_wr_i), .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o),
  .strap_out_clk_high_i(strap_out_clk_high_i), .single_clk_mode_o(single_clk_mode_o),
  .wbuf_ready_o(wbuf_ready_o));

// >>> bbs_ctrl_model.sv
// Memory controller model issuing bursts to the SRAM port.
// Assumes dq_i is the resolved data bus, high impedance when released.
`timescale 1ns/1ps
module bbs_ctrl_model (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [bbs_pkg::DATA_W-1:0] dq_i,
  output logic                            load_strobe_n_o,
  output logic                            rd_not_wr_o,
  output logic [bbs_pkg::ADDR_W-1:0]      addr_o,
  output logic [bbs_pkg::DATA_W-1:0]      wdata_o,
  output logic [bbs_pkg::LANES-1:0]       sel_n_o
);
  logic kph_r;
  // Start idle, a no-operation
  initial begin
    load_strobe_n_o = 1'b1;
    rd_not_wr_o = 1'b1;
    addr_o = '0;
    wdata_o = '0;
    sel_n_o = '1;
  end
  // Phase tracker, high after a K rise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) kph_r <= 1'b0;
    else kph_r <= ~kph_r;
  end
  // Command launched on K-bar so the K rise samples it
  task automatic issue(input logic rd, input logic [bbs_pkg::ADDR_W-1:0] a);
    @(negedge clk_i);
    while (kph_r !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    load_strobe_n_o <= 1'b0;
    rd_not_wr_o <= rd;
    addr_o <= a;
    @(posedge clk_i);
    load_strobe_n_o <= 1'b1;
    addr_o <= ~a;
  endtask
  task automatic wr(input logic [bbs_pkg::ADDR_W-1:0] a, input logic [bbs_pkg::DATA_W-1:0] d0,
                    d1, input logic [bbs_pkg::LANES-1:0] s0, s1);
    issue(1'b0, a);
    @(posedge clk_i);
    wdata_o <= d0;
    sel_n_o <= s0;
    @(posedge clk_i);
    wdata_o <= d1;
    sel_n_o <= s1;
    @(posedge clk_i);
    wdata_o <= ~d1; // Released lines must not echo the last word
    sel_n_o <= '1;
  endtask
  task automatic rd(input logic [bbs_pkg::ADDR_W-1:0] a,
                    output logic [bbs_pkg::DATA_W-1:0] q0, q1, q2);
    issue(1'b1, a);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    q0 = dq_i;
    @(negedge clk_i);
    q1 = dq_i;
    @(negedge clk_i);
    q2 = dq_i; // Returns late enough to leave a NOP before any write
  endtask
  // Strobe low across a K-bar rise only; zero data would show if taken
  task automatic kbar_strobe(input logic [bbs_pkg::ADDR_W-1:0] a);
    @(negedge clk_i);
    while (kph_r !== 1'b0) @(negedge clk_i);
    @(posedge clk_i);
    load_strobe_n_o <= 1'b0;
    rd_not_wr_o <= 1'b0;
    addr_o <= a;
    wdata_o <= '0;
    sel_n_o <= '0;
    @(posedge clk_i);
    load_strobe_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    wdata_o <= '1;
    sel_n_o <= '1;
    @(negedge clk_i);
  endtask
endmodule

// >>> test_bbs_sram_port.sv
// Self-checking bench for the SRAM port driven by the controller model.
// Assumes a 250 MHz clock and the two-lane package setting.
`timescale 1ns/1ps
module test_bbs_sram_port;
  logic                       clk_i;
  logic                       rst_i = 1'b1;
  logic                       strap = 1'b1;
  logic                       ld_n, rnw, oe, scm, rdy;
  logic [bbs_pkg::ADDR_W-1:0] addr;
  logic [bbs_pkg::LANES-1:0]  sel;
  logic [bbs_pkg::DATA_W-1:0] wdata, rdata, dq, q0, q1, q2;
  int                         failures = 0;
  int                         cmp_count = 0;
  int                         cycles = 0;
  assign dq = oe ? rdata : 'z;
  bbs_sram_port u_bbs_sram_port (.clk_i(clk_i), .rst_i(rst_i), .load_strobe_n_i(ld_n),
    .rd_not_wr_i(rnw), .addr_i(addr), .wdata_i(wdata), .lane_write_sel_n_i(sel),
    .strap_out_clk_high_i(strap), .rdata_o(rdata), .rdata_oe_o(oe),
    .single_clk_mode_o(scm), .wbuf_ready_o(rdy));
  bbs_ctrl_model u_bbs_ctrl_model (.clk_i(clk_i), .rst_i(rst_i), .dq_i(dq),
    .load_strobe_n_o(ld_n), .rd_not_wr_o(rnw), .addr_o(addr), .wdata_o(wdata), .sel_n_o(sel));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [bbs_pkg::DATA_W-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [bbs_pkg::ADDR_W-1:0] a,
                        input logic [bbs_pkg::DATA_W-1:0] e0, e1);
    u_bbs_ctrl_model.rd(a, q0, q1, q2);
    check("first beat", q0, e0);
    check("second beat", q1, e1);
    check("released bus", q2, 'z);
  endtask
  // Idle bus and reported strap after reset
  task automatic t_idle();
    repeat (4) @(negedge clk_i);
    check("idle bus", dq, 'z);
    check("strap", scm, 1'b1);
    check("ready", rdy, 1'b1);
  endtask
  // Even and odd start addresses, bypass then array
  task automatic t_burst();
    u_bbs_ctrl_model.wr(20'h00010, 18'h12345, 18'h2ABCD, 2'b00, 2'b00);
    rd_chk(20'h00010, 18'h12345, 18'h2ABCD);
    u_bbs_ctrl_model.wr(20'h00031, 18'h0F0F0, 18'h30303, 2'b00, 2'b00);
    rd_chk(20'h00030, 18'h30303, 18'h0F0F0);
    rd_chk(20'h00011, 18'h2ABCD, 18'h12345);
  endtask
  // Lane selects differ per beat; all high writes nothing
  task automatic t_lanes();
    u_bbs_ctrl_model.wr(20'h00020, 18'h00000, 18'h00000, 2'b00, 2'b00);
    u_bbs_ctrl_model.wr(20'h00020, 18'h3FFFF, 18'h3FFFF, 2'b10, 2'b01);
    u_bbs_ctrl_model.wr(20'h00020, 18'h15555, 18'h15555, 2'b11, 2'b11);
    rd_chk(20'h00020, 18'h001FF, 18'h3FE00);
  endtask
  // Strobe seen only on a K-bar rise is ignored, bus stays off
  task automatic t_nop();
    u_bbs_ctrl_model.kbar_strobe(20'h00020);
    check("nop bus", dq, 'z);
    rd_chk(20'h00020, 18'h001FF, 18'h3FE00);
  endtask
  // Stream of writes through the buffer, read back after
  task automatic t_stream();
    for (int i = 0; i < 10; i++) begin
      u_bbs_ctrl_model.wr(20'h00100 + 20'(2 * i), 18'h01000 + 18'(i), 18'h02000 + 18'(i),
                          2'b00, 2'b00);
    end
    for (int i = 0; i < 10; i++) begin
      rd_chk(20'h00100 + 20'(2 * i), 18'h01000 + 18'(i), 18'h02000 + 18'(i));
    end
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_idle();
    t_burst();
    t_lanes();
    t_nop();
    t_stream();
    give_verdict();
  end
endmodule
